// [common/bsscx_pkg.sv]
// Function
// RL1 - the bit-set instruction, prefix 01 then 01 with a 3-bit index and 7-bit address, sets that bit, keeps flags, takes one cycle.
// RL2 - when the tested bit of the skip-if-set test is zero the next instruction runs normally and the test takes one cycle.
// RL3 - when the tested bit is one the fetched next instruction is discarded and a no-operation cycle runs instead, two cycles in all.
// RL4 - the skip-if-set test decodes from prefix 01 then 11 with index and address and changes no status flag.
// RL5 - a call first pushes its own program counter plus one onto the stack.
// RL6 - a call loads its 11-bit immediate into the low eleven program counter bits.
// RL7 - a call copies bits 4 and 3 of the high latch into program counter bits 12 and 11.
// RL8 - a call takes two cycles, the second doing nothing, and keeps all status flags.
// RL9 - the call opcode is recognised from top bits 100 with the low eleven bits as target.
// RL10 - the clear-register instruction writes zero into the addressed register in one cycle.
// RL11 - the clear-register instruction always sets the zero flag and no other flag.
// RL12 - the clear-register opcode decodes from upper pattern 00 0001 1 with a 7-bit address.
// RL13 - a single-cycle register instruction decodes in phase one, reads in two, computes in three and writes in four.
package bsscx_pkg;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [3:0]  BSSCX_OP_BITSET  = 4'h5;    // 01 01
  localparam logic [3:0]  BSSCX_OP_BITTEST = 4'h7;    // 01 11
  localparam logic [2:0]  BSSCX_OP_CALL    = 3'h4;    // 100
  localparam logic [6:0]  BSSCX_OP_CLEAR   = 7'h03;   // 00 0001 1
  localparam logic [7:0]  BSSCX_CLEAR_VAL  = 8'h00;
  localparam int          BSSCX_LATCH_LO   = 3;       // high latch field bits 4:3
  localparam logic [12:0] BSSCX_PC_RST     = 13'h0000;
  localparam logic [1:0]  BSSCX_PH_DECODE  = 2'h0;
  localparam logic [1:0]  BSSCX_PH_READ    = 2'h1;
  localparam logic [1:0]  BSSCX_PH_PROC    = 2'h2;
  localparam logic [1:0]  BSSCX_PH_WRITE   = 2'h3;

  typedef enum logic [1:0] {BSSCX_XT_NONE, BSSCX_XT_SKIP, BSSCX_XT_CALL} bsscx_extra_t;

  // register-file write request
  typedef struct packed {
    logic       en;
    logic [6:0] addr;
    logic [7:0] data;
  } bsscx_wr_t;

  // stack push request
  typedef struct packed {
    logic        en;
    logic [12:0] addr;
  } bsscx_push_t;

endpackage : bsscx_pkg

// [core/bsscx_core.sv]
`timescale 1ns/1ps
module bsscx_core
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  // instruction fetch side
  input  wire logic [13:0]           instr,
  input  wire logic                  instr_valid,
  input  wire logic [4:0]            pc_high_latch,
  // register file read port, answered in the same phase
  output logic      [6:0]            rd_addr,
  input  wire logic [7:0]            rd_data,
  // results
  output bsscx_pkg::bsscx_wr_t       wr,
  output bsscx_pkg::bsscx_push_t     push,
  output logic      [12:0]           pc,
  output logic                       zero_set,
  output logic      [1:0]            phase,
  output logic                       nop_cycle
);
  import bsscx_pkg::*;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [1:0]   phase_reg;
  logic [1:0]   phase_next;
  logic [13:0]  ir_reg;
  logic [13:0]  ir_next;
  logic [12:0]  pc_reg;
  logic [12:0]  pc_next;
  logic [7:0]   data_reg;
  logic [7:0]   data_next;
  bsscx_extra_t extra_reg;
  bsscx_extra_t extra_next;
  bsscx_wr_t    wr_reg;
  bsscx_wr_t    wr_next;
  bsscx_push_t  push_reg;
  bsscx_push_t  push_next;
  logic         zero_reg;
  logic         zero_next;

  // instruction decode; every decode is masked while a dropped word sits in ir
  wire         in_nop    = (extra_reg != BSSCX_XT_NONE);
  wire         call_tail = (extra_reg == BSSCX_XT_CALL);                  // [RL6]
  wire         is_bitset = !in_nop && ir_reg[13:10] == BSSCX_OP_BITSET;      // [RL1]
  wire         is_test   = !in_nop && ir_reg[13:10] == BSSCX_OP_BITTEST;     // [RL4]
  wire         is_call   = !in_nop && ir_reg[13:11] == BSSCX_OP_CALL;        // [RL9]
  wire         is_clear  = !in_nop && ir_reg[13:7] == BSSCX_OP_CLEAR;        // [RL12]
  wire [2:0]   bit_idx   = ir_reg[9:7];
  wire [7:0]   bit_mask  = 8'h01 << bit_idx;
  wire         bit_hit   = |(data_reg & bit_mask);
  wire [12:0]  call_dest = {pc_high_latch[BSSCX_LATCH_LO+1:BSSCX_LATCH_LO], ir_reg[10:0]}; // [RL6] [RL7]
  wire         cyc_end   = (phase_reg == BSSCX_PH_WRITE);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // phase sequencer and per-phase work; the skip and call second cycles
  // do nothing in any phase, so the fetched word is simply dropped there
  always_comb
  begin
    phase_next = phase_reg + 2'h1;
    ir_next    = ir_reg;
    pc_next    = pc_reg;
    data_next  = data_reg;
    extra_next = extra_reg;
    wr_next    = '0;
    push_next  = '0;
    zero_next  = 1'b0;
    case (phase_reg)
      BSSCX_PH_DECODE: ;
      BSSCX_PH_READ:   data_next = rd_data;                                 // [RL13]
      BSSCX_PH_PROC:
      begin
        if (is_bitset)
          data_next = data_reg | bit_mask;                                  // [RL1]
        else if (is_clear)
          data_next = BSSCX_CLEAR_VAL;                                      // [RL10]
      end
      BSSCX_PH_WRITE:
      begin
        wr_next.en   = is_bitset || is_clear;                               // [RL13]
        wr_next.addr = ir_reg[6:0];
        wr_next.data = data_reg;
        zero_next    = is_clear;                                            // [RL11]
        push_next.en   = is_call;                                           // [RL5]
        push_next.addr = pc_reg + 13'h0001;
        if (is_call)
        begin
          pc_next    = call_dest;                                           // [RL6] [RL7]
          extra_next = BSSCX_XT_CALL;                                       // [RL8]
        end
        else
        begin
          // after a call the target is the next address to run, so the
          // idle second cycle must not step past it
          pc_next    = call_tail ? pc_reg : pc_reg + 13'h0001;              // [RL6] [RL8]
          extra_next = (is_test && bit_hit) ? BSSCX_XT_SKIP : BSSCX_XT_NONE; // [RL2] [RL3]
        end
        ir_next = instr_valid ? instr : 14'h0000;
      end
      default: phase_next = BSSCX_PH_DECODE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // state registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      phase_reg <= BSSCX_PH_DECODE;
      ir_reg    <= 14'h0000;
      pc_reg    <= BSSCX_PC_RST;
      data_reg  <= 8'h00;
      extra_reg <= BSSCX_XT_NONE;
      wr_reg    <= '0;
      push_reg  <= '0;
      zero_reg  <= 1'b0;
    end
    else
    begin
      phase_reg <= phase_next;
      ir_reg    <= ir_next;
      pc_reg    <= pc_next;
      data_reg  <= data_next;
      extra_reg <= extra_next;
      wr_reg    <= wr_next;
      push_reg  <= push_next;
      zero_reg  <= zero_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // outputs; flags other than zero are never touched by this block
  // nop_cycle is decoded from a flop, so it stands for the whole cycle
  assign rd_addr   = ir_reg[6:0];
  assign wr        = wr_reg;
  assign push      = push_reg;
  assign pc        = pc_reg;
  assign zero_set  = zero_reg;
  assign phase     = phase_reg;
  assign nop_cycle = in_nop;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  skip_takes_nop_a: assert property (@(posedge clk) disable iff (srst) // [RL3]
    (cyc_end && is_test && bit_hit) |=> nop_cycle [*4])
    else $error("skip did not insert a nop cycle");
  noskip_runs_a: assert property (@(posedge clk) disable iff (srst) // [RL2]
    (cyc_end && is_test && !bit_hit) |=> !nop_cycle)
    else $error("clear bit still skipped");
  call_push_a: assert property (@(posedge clk) disable iff (srst) // [RL5]
    (cyc_end && is_call) |=> push.en && push.addr == $past(pc_reg) + 13'h0001)
    else $error("call pushed wrong return address");
  call_target_a: assert property (@(posedge clk) disable iff (srst) // [RL6]
    (cyc_end && is_call) |=> pc[10:0] == $past(ir_reg[10:0]))
    else $error("call target low bits wrong");
  call_upper_a: assert property (@(posedge clk) disable iff (srst) // [RL7]
    (cyc_end && is_call) |=> pc[12:11] == $past(pc_high_latch[4:3]))
    else $error("call upper bits wrong");
  call_idle_a: assert property (@(posedge clk) disable iff (srst) // [RL8]
    (cyc_end && is_call) |=> (nop_cycle && !wr.en && !zero_set) [*4])
    else $error("call second cycle not idle");
  clear_write_a: assert property (@(posedge clk) disable iff (srst) // [RL10]
    (cyc_end && is_clear) |=> wr.en && wr.data == BSSCX_CLEAR_VAL)
    else $error("clear did not write zero");
  clear_zero_a: assert property (@(posedge clk) disable iff (srst) // [RL11]
    zero_set |-> $past(is_clear))
    else $error("zero flag set without clear");
  bitset_write_a: assert property (@(posedge clk) disable iff (srst) // [RL1]
    (cyc_end && is_bitset) |=> wr.en && wr.data[$past(bit_idx)] && !zero_set)
    else $error("bit set wrong");
  write_phase_a: assert property (@(posedge clk) disable iff (srst) // [RL13]
    wr.en |-> phase == BSSCX_PH_DECODE)
    else $error("write outside phase four");
  test_noflag_a: assert property (@(posedge clk) disable iff (srst) // [RL4]
    (cyc_end && is_test) |=> !wr.en && !zero_set)
    else $error("bit test changed state");
  call_decode_a: assert property (@(posedge clk) disable iff (srst) // [RL9]
    push.en |-> $past(ir_reg[13:11]) == BSSCX_OP_CALL)
    else $error("push without call opcode");
  clear_decode_a: assert property (@(posedge clk) disable iff (srst) // [RL12]
    zero_set |-> $past(ir_reg[13:7]) == BSSCX_OP_CLEAR)
    else $error("zero flag without clear opcode");

  // ----------------------------------------------------------------
  // checks on the phases, the program counter, the merged byte, the discarded word and the write addresses
  // ----------------------------------------------------------------
  // the read port is combinational, so the byte must be captured at the
  // read-phase edge; a late capture would leave the process phase working on the old byte
  read_phase_a: assert property (@(posedge clk) disable iff (srst) // [RL13]
    (phase == BSSCX_PH_PROC) |-> data_reg == $past(rd_data))
    else $error("register byte not captured in read phase");
  phase_wrap_a: assert property (@(posedge clk) disable iff (srst) // [RL13]
    (phase == BSSCX_PH_WRITE) |=> phase == BSSCX_PH_DECODE)
    else $error("phase did not wrap after write");
  bitset_merge_a: assert property (@(posedge clk) disable iff (srst) // [RL1]
    (phase == BSSCX_PH_PROC && is_bitset) |=> data_reg == ($past(data_reg) | $past(bit_mask)))
    else $error("bit set disturbed other bits");
  nop_quiet_a: assert property (@(posedge clk) disable iff (srst) // [RL3]
    (cyc_end && in_nop) |=> !wr.en && !push.en && !zero_set)
    else $error("discarded word had an effect");
  skip_pc_a: assert property (@(posedge clk) disable iff (srst) // [RL3]
    (cyc_end && extra_reg == BSSCX_XT_SKIP) |=> pc == $past(pc) + 13'h0001)
    else $error("skip cycle did not step the program counter");
  test_pc_a: assert property (@(posedge clk) disable iff (srst) // [RL2]
    (cyc_end && is_test && !bit_hit) |=> pc == $past(pc) + 13'h0001)
    else $error("clear bit test did not step the program counter");
  call_land_a: assert property (@(posedge clk) disable iff (srst) // [RL6]
    (cyc_end && call_tail) |=> $stable(pc))
    else $error("program counter left the call target");
  clear_addr_a: assert property (@(posedge clk) disable iff (srst) // [RL10]
    (cyc_end && is_clear) |=> wr.addr == $past(ir_reg[6:0]))
    else $error("clear wrote the wrong register");
  bitset_addr_a: assert property (@(posedge clk) disable iff (srst) // [RL1]
    (cyc_end && is_bitset) |=> wr.addr == $past(ir_reg[6:0]) && !push.en)
    else $error("bit set wrote the wrong register");

endmodule : bsscx_core

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
  import bsscx_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                 clk;
  logic                 srst;
  logic        [13:0]   instr;
  logic                 instr_valid;
  logic        [4:0]    pc_high_latch;
  logic        [4:0]    lat_q;
  logic        [6:0]    rd_addr;
  logic        [7:0]    rd_data;
  bsscx_wr_t            wr;
  bsscx_push_t          push;
  logic        [12:0]   pc;
  logic                 zero_set;
  logic        [1:0]    phase;
  logic                 nop_cycle;
  logic        [7:0]    rf [128];
  int                   n_fail;
  int                   comparisons;

  bsscx_core i_dut (.clk(clk), .srst(srst), .instr(instr), .instr_valid(instr_valid),
    .pc_high_latch(pc_high_latch), .rd_addr(rd_addr), .rd_data(rd_data), .wr(wr),
    .push(push), .pc(pc), .zero_set(zero_set), .phase(phase), .nop_cycle(nop_cycle));

  // register file model answers in the same phase, as the read port expects
  assign rd_data = rf[rd_addr];

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one instruction cycle; returns settled after the edge that takes the word
  task cyc(input logic [13:0] w);
    @(posedge clk);
    instr         <= w;
    instr_valid   <= |w;
    pc_high_latch <= lat_q;
    repeat (3) @(posedge clk);
    #1;
  endtask : cyc

  task close_out;
    $display("Mismatches %0d, comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // every bit index, back to back, so a stale register read would show
  task t_bitset;
    logic [12:0] p;
    p = pc;
    for (int b = 0; b < 9; b++)
    begin
      logic [2:0] bi;
      logic [2:0] bm;
      bi = b[2:0];
      bm = bi - 3'h1;
      rf[{4'h4, bi}] = 8'h0A;
      cyc((b < 8) ? {BSSCX_OP_BITSET, bi, 4'h4, bi} : 14'h0000);
      p = p + 13'h1;
      chk(pc, p);
      chk(phase, 2'h0);
      if (b > 0) chk(wr, {1'b1, 4'h4, bm, 8'h0A | (8'h01 << bm)});
      if (b > 0) chk(zero_set, 1'h0);
    end
  endtask : t_bitset

  task t_clear;
    rf[7'h7F] = 8'h5A;
    cyc({BSSCX_OP_CLEAR, 7'h7F});
    cyc({BSSCX_OP_CLEAR ^ 7'h01, 7'h7F});
    chk(wr, {1'b1, 7'h7F, 8'h00});
    chk(zero_set, 1'h1);
    cyc(14'h0000);
    chk(zero_set, 1'h0);
    chk(wr.en, 1'h0);
  endtask : t_clear

  // the word after the test is dropped only when the bit is set
  task t_skip(input logic s);
    rf[7'h11] = s ? 8'h02 : 8'hFD;
    cyc({BSSCX_OP_BITTEST, 3'h1, 7'h11});
    cyc({BSSCX_OP_CLEAR, 7'h31});
    chk(nop_cycle, s);
    chk(wr.en, 1'h0);
    chk(zero_set, 1'h0);
    cyc({BSSCX_OP_CLEAR, 7'h32});
    chk(wr.en, !s);
    chk(zero_set, !s);
    cyc(14'h0000);
    chk(wr, {1'b1, 7'h32, 8'h00});
  endtask : t_skip

  task t_call(input logic [4:0] l, input logic [10:0] k);
    logic [12:0] p;
    lat_q = l;
    cyc({BSSCX_OP_CALL, k});
    p = pc;
    cyc({BSSCX_OP_CLEAR, 7'h33});
    chk(push, {1'b1, p + 13'h1});
    chk(pc, {l[4:3], k});
    chk(nop_cycle, 1'h1);
    chk(zero_set, 1'h0);
    cyc({BSSCX_OP_CLEAR, 7'h34});
    chk(wr.en, 1'h0);
    chk(push.en, 1'h0);
    chk(pc, {l[4:3], k});
    cyc(14'h0000);
    chk(wr, {1'b1, 7'h34, 8'h00});
    chk(pc, {l[4:3], k} + 13'h0001);
  endtask : t_call

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    srst = 1'b1;
    instr = 14'h0000;
    instr_valid = 1'b0;
    pc_high_latch = 5'h00;
    lat_q = 5'h00;
    foreach (rf[i]) rf[i] = 8'h00;
    repeat (3) @(posedge clk);
    #1;
    chk(pc, 13'h0000);
    chk(phase, 2'h0);
    @(posedge clk);
    srst <= 1'b0;
    #1;
    for (int i = 0; i < 8 && phase !== 2'h3; i++)
    begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    t_bitset();
    t_clear();
    t_skip(1'b1);
    t_skip(1'b0);
    t_call(5'h17, 11'h7FF);
    t_call(5'h08, 11'h000);
    close_out();
  end

  // the scenarios need well under 300 clocks
  initial
  begin
    repeat (2000) @(posedge clk);
    n_fail++;
    close_out();
  end
endmodule : tb
